/* File: ospp_postprocess.v */
// Purpose: register file, self-calibration sequencer, proximity mode control,
//   sub-range change tagging and outlier detect-and-replace for each sample
// Assumes: one conversion per conv_valid pulse; register port synchronous to clk_sys
// Notes: the analog converter, LED drivers and FIFO storage sit outside
`include "ospp_defs.vh"

module ospp_postprocess #(
  parameter CAL_CYCLES = `OSPP_CAL_CYCLES,
  parameter SUB_SHIFT = 14
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire conv_valid,
  input wire [4:0] conv_subrange,
  input wire [15:0] conv_integrator,
  input wire [2:0] conv_slot,
  input wire conv_pd_one,
  input wire [4:0] conv_tag,
  input wire cal_finished,
  input wire cal_out_of_range,
  output reg cal_run,
  output reg seq_start,
  output reg seq_running,
  output reg prox_mode,
  output reg low_power,
  output reg [7:0] first_slot_current,
  output reg [4:0] sample_rate_select,
  output wire slot_skip,
  output reg fifo_valid,
  output reg [23:0] fifo_word
);
  // host-owned configuration
  reg [7:0] irq_enable_second;
  reg [7:0] irq_enable_third;
  reg [7:0] sys_control;
  reg [7:0] sync_control;
  reg [7:0] conversion_config_one;
  reg [7:0] conversion_config_two;
  reg [7:0] settling;
  reg [7:0] proximity_threshold_reg;
  reg [7:0] outlier_filter_config;
  reg [7:0] sequence_reg;
  reg [7:0] proximity_led_current;
  reg [7:0] led_normal_current;
  reg prox_irq, cal_done, cal_oor;
  reg [31:0] cal_count;
  reg [4:0] last_subrange;
  reg have_subrange;
  // outlier filter state
  reg [18:0] hist0, hist1, hist2, hist3;
  reg [2:0] hist_count;
  reg [23:0] lpf;
  reg filt_active;

  wire [18:0] sample;
  wire [1:0] tc_code = outlier_filter_config[5:4];
  wire [1:0] init_code = outlier_filter_config[3:2];
  wire [23:0] lpf_init = {6'h00, init_code, 16'h0000};
  wire [1:0] mult_code = outlier_filter_config[1:0];
  wire filter_en = outlier_filter_config[`OSPP_BIT_FILTER_EN];
  wire order = outlier_filter_config[`OSPP_BIT_ORDER];
  wire prox_en = irq_enable_second[`OSPP_BIT_PROX];

  // redundant sub-range bits overlap the integrator's top bits; the carry out is dropped
  wire [19:0] sample_sum = {1'b0, {14'h0000, conv_subrange} << SUB_SHIFT} +
    {4'h0, conv_integrator};
  assign sample = sample_sum[18:0];
  assign slot_skip = prox_mode;

  // register writes
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable_second <= 8'h00;
      irq_enable_third <= 8'h00;
      sys_control <= 8'h00;
      sync_control <= 8'h00;
      conversion_config_one <= 8'h00;
      conversion_config_two <= 8'h00;
      settling <= 8'h00;
      proximity_threshold_reg <= 8'h00;
      outlier_filter_config <= 8'h00;
      sequence_reg <= 8'h00;
      proximity_led_current <= 8'h00;
      led_normal_current <= 8'h00;
      seq_start <= 1'b0;
    end else begin
      seq_start <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `OSPP_REG_IRQ_ENABLE_TWO) begin
          irq_enable_second <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_IRQ_ENABLE_THREE) begin
          irq_enable_third <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_SYS_CONTROL) begin
          sys_control <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_SYNC_CONTROL) begin
          sync_control <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_CONV_CONFIG_ONE) begin
          conversion_config_one <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_CONV_CONFIG_TWO) begin
          conversion_config_two <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_SETTLING) begin
          settling <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_PROX_THRESHOLD) begin
          proximity_threshold_reg <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_OUTLIER_CONFIG) begin
          outlier_filter_config <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_SEQUENCE) begin
          sequence_reg <= reg_wdata;
          seq_start <= (reg_wdata != 8'h00);
        end else if (reg_addr == `OSPP_REG_PILOT_CURRENT) begin
          proximity_led_current <= reg_wdata;
        end else if (reg_addr == `OSPP_REG_LED_NORMAL) begin
          led_normal_current <= reg_wdata;
        end
      end
    end
  end

  // self-calibration: start bit launches a timed run; done and oor stick until next start
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cal_run <= 1'b0;
      cal_done <= 1'b0;
      cal_oor <= 1'b0;
      cal_count <= 32'h00000000;
    end else if (reg_wr && reg_addr == `OSPP_REG_SUBRANGE_CAL &&
                 reg_wdata[`OSPP_BIT_CAL_START]) begin
      cal_run <= 1'b1;
      cal_done <= 1'b0;
      cal_oor <= 1'b0;
      cal_count <= 32'h00000000;
    end else if (cal_run) begin
      cal_count <= cal_count + 32'h00000001;
      if (cal_finished || cal_count >= CAL_CYCLES - 1) begin
        cal_run <= 1'b0;
        cal_done <= 1'b1;
        cal_oor <= cal_out_of_range;
      end
    end
  end

  // sequencer runs while the sequence register holds a nonzero pattern and no calibration is running
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seq_running <= 1'b0;
    end else begin
      seq_running <= (sequence_reg != 8'h00) && !cal_run;
    end
  end

  // proximity mode; status bit clears on read, a same-cycle event wins
  wire first_slot = conv_valid && conv_slot == 3'h0 && conv_pd_one;
  // threshold register counts in 2048-LSB steps
  wire [18:0] prox_level = {proximity_threshold_reg, 11'h000};
  wire prox_enter = prox_en && !prox_mode && first_slot && sample < prox_level;
  wire prox_leave = prox_en && prox_mode && first_slot && sample > prox_level;
  wire status_rd = reg_rd && reg_addr == `OSPP_REG_PROX_STATUS;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prox_mode <= 1'b0;
      prox_irq <= 1'b0;
    end else begin
      if (prox_enter) begin
        prox_mode <= 1'b1;
      end else if (prox_leave || !prox_en) begin
        prox_mode <= 1'b0;
      end
      if (prox_enter || prox_leave) begin
        prox_irq <= 1'b1;
      end else if (status_rd) begin
        prox_irq <= 1'b0;
      end
    end
  end

  // operating point follows the mode without host involvement
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      first_slot_current <= 8'h00;
      sample_rate_select <= 5'h00;
      low_power <= 1'b0;
    end else if (prox_mode) begin
      first_slot_current <= proximity_led_current;
      sample_rate_select <= `OSPP_PROX_RATE_CODE;
      low_power <= 1'b1;
    end else begin
      first_slot_current <= led_normal_current;
      sample_rate_select <= conversion_config_two[7:3];
      low_power <= 1'b0;
    end
  end

  // outlier prediction
  // least-squares line through the last four outputs, taken one step on;
  // reduces to p = h0 + (h1 - h3)/2, clamped into 19 bits below
  wire signed [22:0] extrap = $signed({4'h0, hist0}) +
    ($signed({4'h0, hist1}) - $signed({4'h0, hist3})) / 23'sd2;
  reg [18:0] predict;
  always @* begin
    predict = hist0;
    if (order && hist_count == 3'h4) begin
      if (extrap < 0) begin
        predict = 19'h00000;
      end else if (extrap > 23'sh07FFFF) begin
        predict = 19'h7FFFF;
      end else begin
        predict = extrap[18:0];
      end
    end
  end
  wire [18:0] diff = sample > predict ? sample - predict : predict - sample;
  wire [23:0] diff_w = {5'h00, diff};
  // both factors are powers of two, so shifts stand in for the divide and the product
  reg [2:0] tc_shift;
  reg [2:0] mult_shift;
  always @* begin
    case (tc_code)
      2'h0: tc_shift = 3'h3;
      2'h1: tc_shift = 3'h4;
      2'h2: tc_shift = 3'h5;
      default: tc_shift = 3'h6;
    endcase
    case (mult_code)
      2'h0: mult_shift = 3'h2;
      2'h1: mult_shift = 3'h3;
      2'h2: mult_shift = 3'h4;
      default: mult_shift = 3'h5;
    endcase
  end

  reg [23:0] lpf_step;
  reg [23:0] lpf_next;
  reg [28:0] thresh;
  always @* begin
    if (diff_w >= lpf) begin
      lpf_step = (diff_w - lpf) >> tc_shift;
    end else begin
      lpf_step = ~((lpf - diff_w) >> tc_shift) + 24'h000001;
    end
    // the present error enters the average before the compare
    if (filt_active) begin
      lpf_next = lpf + lpf_step;
    end else begin
      lpf_next = lpf_init;
    end
    thresh = {5'h00, lpf_next} << mult_shift;
  end
  wire outlier = filt_active && hist_count != 3'h0 && {10'h000, diff} > thresh;
  wire [18:0] out_value = (filter_en && outlier) ? predict : sample;

  // filter state advances once per conversion
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hist0 <= 19'h00000;
      hist1 <= 19'h00000;
      hist2 <= 19'h00000;
      hist3 <= 19'h00000;
      hist_count <= 3'h0;
      lpf <= 24'h000000;
      filt_active <= 1'b0;
    end else if (!filter_en) begin
      hist_count <= 3'h0;
      filt_active <= 1'b0;
    end else if (conv_valid) begin
      hist0 <= out_value;
      hist1 <= hist0;
      hist2 <= hist1;
      hist3 <= hist2;
      if (hist_count != 3'h4) begin
        hist_count <= hist_count + 3'h1;
      end
      if (!filt_active) begin
        lpf <= lpf_init;
        filt_active <= 1'b1;
      end else begin
        lpf <= lpf_next;
      end
    end
  end

  // tagged output word
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      last_subrange <= 5'h00;
      have_subrange <= 1'b0;
      fifo_valid <= 1'b0;
      fifo_word <= 24'h000000;
    end else begin
      fifo_valid <= conv_valid && (!prox_mode || conv_slot == 3'h0);
      if (conv_valid) begin
        last_subrange <= conv_subrange;
        have_subrange <= 1'b1;
        if (sync_control[`OSPP_BIT_SUBRANGE_TAG] && have_subrange &&
            conv_subrange != last_subrange) begin
          fifo_word <= {`OSPP_SUBRANGE_CHANGE_TAG, out_value};
        end else begin
          fifo_word <= {conv_tag, out_value};
        end
      end
    end
  end

  // register read, data in the cycle after the strobe
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `OSPP_REG_PROX_STATUS) begin
        reg_rdata <= {3'h0, prox_irq, 4'h0};
      end else if (reg_addr == `OSPP_REG_IRQ_ENABLE_TWO) begin
        reg_rdata <= irq_enable_second;
      end else if (reg_addr == `OSPP_REG_IRQ_ENABLE_THREE) begin
        reg_rdata <= irq_enable_third;
      end else if (reg_addr == `OSPP_REG_SYS_CONTROL) begin
        reg_rdata <= sys_control;
      end else if (reg_addr == `OSPP_REG_SYNC_CONTROL) begin
        reg_rdata <= sync_control;
      end else if (reg_addr == `OSPP_REG_CONV_CONFIG_ONE) begin
        reg_rdata <= conversion_config_one;
      end else if (reg_addr == `OSPP_REG_CONV_CONFIG_TWO) begin
        reg_rdata <= conversion_config_two;
      end else if (reg_addr == `OSPP_REG_SETTLING) begin
        reg_rdata <= settling;
      end else if (reg_addr == `OSPP_REG_PROX_THRESHOLD) begin
        reg_rdata <= proximity_threshold_reg;
      end else if (reg_addr == `OSPP_REG_OUTLIER_CONFIG) begin
        reg_rdata <= outlier_filter_config;
      end else if (reg_addr == `OSPP_REG_SEQUENCE) begin
        reg_rdata <= sequence_reg;
      end else if (reg_addr == `OSPP_REG_PILOT_CURRENT) begin
        reg_rdata <= proximity_led_current;
      end else if (reg_addr == `OSPP_REG_LED_NORMAL) begin
        reg_rdata <= led_normal_current;
      end else if (reg_addr == `OSPP_REG_SUBRANGE_CAL) begin
        reg_rdata <= {5'h00, cal_oor, cal_done, cal_run};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // ospp_postprocess

/* File: ospp_defs.vh */
// Purpose: constants for the optical sample post-processing block
// Assumes: 8-bit register port, 20 MHz system clock
// Notes: offsets are register indices as seen on the register port
`ifndef OSPP_DEFS_VH
`define OSPP_DEFS_VH
`define OSPP_REG_IRQ_STATUS_ONE 8'h00
`define OSPP_REG_PROX_STATUS 8'h01
`define OSPP_REG_IRQ_ENABLE_TWO 8'h02
`define OSPP_REG_IRQ_ENABLE_THREE 8'h03
`define OSPP_REG_SYS_CONTROL 8'h0D
`define OSPP_REG_SYNC_CONTROL 8'h10
`define OSPP_REG_CONV_CONFIG_ONE 8'h11
`define OSPP_REG_CONV_CONFIG_TWO 8'h12
`define OSPP_REG_SETTLING 8'h13
`define OSPP_REG_PROX_THRESHOLD 8'h14
`define OSPP_REG_OUTLIER_CONFIG 8'h16
`define OSPP_REG_SEQUENCE 8'h20
`define OSPP_REG_PILOT_CURRENT 8'h29
`define OSPP_REG_SUBRANGE_CAL 8'h50
`define OSPP_REG_LED_NORMAL 8'h23
`define OSPP_BIT_PROX 4
`define OSPP_BIT_SUBRANGE_TAG 5
`define OSPP_BIT_CAL_START 0
`define OSPP_BIT_CAL_DONE 1
`define OSPP_BIT_CAL_OOR 2
`define OSPP_BIT_FILTER_EN 7
`define OSPP_BIT_ORDER 6
`define OSPP_SUBRANGE_CHANGE_TAG 5'h1D
`define OSPP_PROX_THRESH_SHIFT 11
`define OSPP_PROX_RATE_CODE 5'h1F
`define OSPP_CAL_TIME_MS 200
`define OSPP_CLK_HZ 20000000
`define OSPP_CAL_CYCLES (`OSPP_CAL_TIME_MS * (`OSPP_CLK_HZ / 1000))
`endif

/* File: ospp_pp_asserts.sv */
// Purpose: port-level temporal checks for the post-processing block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: filter and tag enables are shadowed from register writes
module ospp_pp_asserts #(
  parameter CAL_CYCLES = 50,
  parameter SUB_SHIFT = 14
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire conv_valid,
  input wire [4:0] conv_subrange,
  input wire [15:0] conv_integrator,
  input wire [2:0] conv_slot,
  input wire [4:0] conv_tag,
  input wire cal_run,
  input wire seq_start,
  input wire prox_mode,
  input wire low_power,
  input wire [4:0] sample_rate_select,
  input wire slot_skip,
  input wire fifo_valid,
  input wire [23:0] fifo_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  reg filt_en;
  reg tag_en;
  reg seen;
  reg [4:0] last_sub;
  reg [31:0] cal_cnt;
  wire [18:0] raw = ({14'h0000, conv_subrange} << SUB_SHIFT) + {3'h0, conv_integrator};
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      filt_en <= 1'b0;
      tag_en <= 1'b0;
      seen <= 1'b0;
      last_sub <= 5'h00;
      cal_cnt <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h16) filt_en <= reg_wdata[7];
      if (reg_wr && reg_addr == 8'h10) tag_en <= reg_wdata[5];
      if (conv_valid) seen <= 1'b1;
      if (conv_valid) last_sub <= conv_subrange;
      cal_cnt <= cal_run ? cal_cnt + 32'h1 : 32'h0;
    end
  end
  sequence s_cal_req;
    reg_wr && reg_addr == 8'h50 && reg_wdata[0];
  endsequence
  sequence s_plain_conv;
    conv_valid && !prox_mode;
  endsequence
  property p_cal_start; s_cal_req |=> cal_run; endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
  // a stuck run flag would hold off the done bit forever
  property p_cal_len; cal_cnt <= CAL_CYCLES + 1; endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration overran");
  property p_seq; reg_wr && reg_addr == 8'h20 && reg_wdata != 8'h00 |=> seq_start; endproperty
  a_seq: assert property (p_seq) else $error("sequence start missing");
  property p_fifo_lat; s_plain_conv |=> fifo_valid; endproperty
  a_fifo_lat: assert property (p_fifo_lat) else $error("fifo word missing");
  property p_no_spurious; !conv_valid |=> !fifo_valid; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("fifo word without sample");
  property p_raw;
    s_plain_conv ##0 (!filt_en && !tag_en) |=> fifo_word == {$past(conv_tag), $past(raw)};
  endproperty
  a_raw: assert property (p_raw) else $error("fifo word content wrong");
  property p_tag;
    s_plain_conv ##0 (tag_en && seen && conv_subrange != last_sub) |=> fifo_word[23:19] == 5'h1D;
  endproperty
  a_tag: assert property (p_tag) else $error("change tag missing");
  property p_prox_rate;
    prox_mode && $past(prox_mode) |-> sample_rate_select == 5'h1F && low_power;
  endproperty
  a_prox_rate: assert property (p_prox_rate) else $error("proximity rate or power wrong");
  property p_prox_src;
    $rose(prox_mode) |-> $past(conv_valid) && $past(conv_slot) == 3'h0;
  endproperty
  a_prox_src: assert property (p_prox_src) else $error("prox entry off first slot");
  property p_skip_drop; conv_valid && slot_skip && conv_slot != 3'h0 |=> !fifo_valid; endproperty
  a_skip_drop: assert property (p_skip_drop) else $error("skipped slot reached fifo");
endmodule // ospp_pp_asserts

bind ospp_postprocess ospp_pp_asserts #(.CAL_CYCLES(CAL_CYCLES), .SUB_SHIFT(SUB_SHIFT))
  i_ospp_pp_asserts (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .conv_valid(conv_valid),
  .conv_subrange(conv_subrange), .conv_integrator(conv_integrator), .conv_slot(conv_slot),
  .conv_tag(conv_tag), .cal_run(cal_run), .seq_start(seq_start), .prox_mode(prox_mode),
  .low_power(low_power), .sample_rate_select(sample_rate_select), .slot_skip(slot_skip),
  .fifo_valid(fifo_valid), .fifo_word(fifo_word));

/* File: ospp_host_fifo.sv */
// Purpose: host-side sink that takes each fifo word as it is pushed
// Assumes: words are pushed one per fifo_valid pulse
// Notes: keeps only the latest word and a running count
module ospp_host_fifo (
  input wire clk_sys,
  input wire arst_n,
  input wire fifo_valid,
  input wire [23:0] fifo_word,
  output logic [23:0] host_word,
  output logic [15:0] host_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      host_word <= 24'h000000;
      host_cnt <= 16'h0000;
    end else if (fifo_valid) begin
      host_word <= fifo_word;
      host_cnt <= host_cnt + 16'h0001;
    end
  end
endmodule // ospp_host_fifo

/* File: test_ospp_postprocess.sv */
// Purpose: register, calibration, tag, proximity and filter tests
// Assumes: calibration shortened to 50 cycles
// Notes: conversions are fed by the bench in place of the converter
module test_ospp_postprocess;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, arst_n, reg_wr, reg_rd, conv_valid, conv_pd_one, cal_finished;
  logic cal_out_of_range, cal_run, seq_start, seq_running, prox_mode, low_power;
  logic slot_skip, fifo_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, first_slot_current;
  logic [4:0] conv_subrange, conv_tag, sample_rate_select;
  logic [15:0] conv_integrator, host_cnt, exp_cnt;
  logic [2:0] conv_slot;
  logic [23:0] fifo_word, host_word;
  logic [7:0] zero_regs [7] = '{8'h02, 8'h03, 8'h0D, 8'h10, 8'h12, 8'h13, 8'h20};
  int error_cnt, checks_done, k;
  ospp_postprocess #(.CAL_CYCLES(50)) i_ospp_postprocess (.clk_sys(clk_sys),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
    .conv_subrange(conv_subrange), .conv_integrator(conv_integrator), .conv_slot(conv_slot),
    .conv_pd_one(conv_pd_one), .conv_tag(conv_tag), .cal_finished(cal_finished),
    .cal_out_of_range(cal_out_of_range), .cal_run(cal_run), .seq_start(seq_start),
    .seq_running(seq_running), .prox_mode(prox_mode), .low_power(low_power),
    .first_slot_current(first_slot_current), .sample_rate_select(sample_rate_select),
    .slot_skip(slot_skip), .fifo_valid(fifo_valid), .fifo_word(fifo_word));
  ospp_host_fifo i_ospp_host_fifo (.clk_sys(clk_sys), .arst_n(arst_n),
    .fifo_valid(fifo_valid), .fifo_word(fifo_word), .host_word(host_word), .host_cnt(host_cnt));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic cmpv(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t value got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmpf(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t flag got %b want %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 cmpv({16'h0000, reg_rdata}, {16'h0000, e});
  endtask
  task automatic conv(input logic [4:0] s, input logic [15:0] v, input logic [2:0] sl,
                      input logic vld, input logic [23:0] w);
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_subrange <= s;
    conv_integrator <= v;
    conv_slot <= sl;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    #1 cmpf(fifo_valid, vld);
    if (vld) begin
      exp_cnt++;
      @(posedge clk_sys);
      #1 cmpv(host_word, w);
    end
  endtask
  // polls after each edge has settled, so no race with the run flag update
  task automatic wait_cal(input int n);
    int i;
    for (i = 0; i < n && cal_run === 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    cmpf(cal_run, 1'b0);
  endtask
  task automatic prox_state(input logic m, input logic [7:0] cur, input logic [4:0] sr);
    @(posedge clk_sys);
    #1 cmpf(prox_mode, m);
    cmpf(low_power, m);
    cmpf(slot_skip, m);
    cmpv({16'h0000, first_slot_current}, {16'h0000, cur});
    cmpv({19'h00000, sample_rate_select}, {19'h00000, sr});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial begin
    {arst_n, reg_wr, reg_rd, conv_valid, cal_finished} = 5'h00;
    {reg_addr, reg_wdata, conv_subrange, conv_integrator, conv_slot} = 40'h0;
    {conv_pd_one, conv_tag, cal_out_of_range, exp_cnt} = {1'b1, 5'h01, 1'b1, 16'h0000};
    error_cnt = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(8'h16, 8'h00);
    rd(8'h7F, 8'h00);
    foreach (zero_regs[i]) wr(zero_regs[i], 8'h00);
    wr(8'h11, 8'h0B);
    wr(8'h50, 8'h01);
    #1 cmpf(cal_run, 1'b1);
    wait_cal(60);
    rd(8'h50, 8'h06);
    cal_out_of_range <= 1'b0;
    wr(8'h50, 8'h01);
    cal_finished <= 1'b1;
    @(posedge clk_sys);
    cal_finished <= 1'b0;
    #1 wait_cal(4);
    rd(8'h50, 8'h02);
    cmpf(seq_running, 1'b0);
    wr(8'h20, 8'h21);
    #1 cmpf(seq_start, 1'b1);
    conv(5'h03, 16'h1234, 3'h1, 1'b1, {5'h01, 19'h0D234});
    cmpf(seq_running, 1'b1);
    wr(8'h10, 8'h20);
    conv(5'h03, 16'h0010, 3'h1, 1'b1, {5'h01, 19'h0C010});
    conv(5'h04, 16'h0010, 3'h1, 1'b1, {5'h1D, 19'h10010});
    conv(5'h00, 16'h0010, 3'h1, 1'b1, {5'h1D, 19'h00010});
    wr(8'h10, 8'h00);
    conv(5'h02, 16'h0000, 3'h1, 1'b1, {5'h01, 19'h08000});
    wr(8'h12, 8'h18);
    wr(8'h23, 8'h40);
    wr(8'h14, 8'h02);
    wr(8'h29, 8'h05);
    wr(8'h02, 8'h10);
    rd(8'h14, 8'h02);
    conv(5'h00, 16'h0FFF, 3'h0, 1'b1, {5'h01, 19'h00FFF});
    prox_state(1'b1, 8'h05, 5'h1F);
    rd(8'h01, 8'h10);
    rd(8'h01, 8'h00);
    conv(5'h00, 16'h0100, 3'h2, 1'b0, 24'h000000);
    conv(5'h00, 16'h1001, 3'h0, 1'b1, {5'h01, 19'h01001});
    prox_state(1'b0, 8'h40, 5'h03);
    rd(8'h01, 8'h10);
    wr(8'h02, 8'h00);
    for (k = 0; k < 3; k++) begin
      wr(8'h16, k == 0 ? 8'h80 : (k == 1 ? 8'hC0 : 8'h83));
      repeat (5) conv(5'h00, 16'h0000, 3'h1, 1'b1, {5'h01, 19'h00000});
      conv(5'h00, 16'h1F40, 3'h1, 1'b1, {5'h01, k == 2 ? 19'h01F40 : 19'h00000});
    end
    wr(8'h16, 8'h00);
    conv(5'h00, 16'h1F40, 3'h1, 1'b1, {5'h01, 19'h01F40});
    cmpv({8'h00, host_cnt}, {8'h00, exp_cnt});
    complete_run();
  end
endmodule // test_ospp_postprocess
